// ---- pkg/atri_defines.vh ----
// constants of the asynchronous timer register interface
// assumes: included by bare name from the design files under verilog/
`ifndef ATRI_DEFINES_VH
`define ATRI_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets (one aligned word each)
// ----------------------------------------------------------------
`define ATRI_OFF_COUNTER  8'h00
`define ATRI_OFF_COMPARE  8'h04
`define ATRI_OFF_CONTROL  8'h08
`define ATRI_OFF_ASYNC    8'h0C
`define ATRI_OFF_MASK     8'h10
`define ATRI_OFF_FLAGS    8'h14
`define ATRI_OFF_SFIO     8'h18
`define ATRI_OFF_GIE      8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATRI_AS_SEL_BIT   3
`define ATRI_CNT_BUSY_BIT 2
`define ATRI_CMP_BUSY_BIT 1
`define ATRI_CTL_BUSY_BIT 0
`define ATRI_CMP_IE_BIT   7
`define ATRI_OVF_IE_BIT   6
`define ATRI_CMP_FLG_BIT  7
`define ATRI_OVF_FLG_BIT  6
`define ATRI_PSR_BIT      1
`define ATRI_GIE_BIT      7
`define ATRI_FOC_BIT      7
`define ATRI_WGM1_BIT     6
`define ATRI_WGM0_BIT     3
`define ATRI_COM_HI       5
`define ATRI_COM_LO       4

// ----------------------------------------------------------------
// reset values and fixed figures
// ----------------------------------------------------------------
`define ATRI_RST_BYTE     8'h00
`define ATRI_CNT_MAX      8'hFF
`define ATRI_CNT_BOTTOM   8'h00
`define ATRI_FLAG_DLY     3
`define ATRI_RESP_OKAY    2'b00
`define ATRI_RESP_DECERR  2'b11

`endif

// ---- tb/atri_monitor.sv ----
// bus handshake checker for the timer register interface
// assumes: bound to atri_top; one clock, aclk, with active-low reset
`timescale 1ns/1ns
// ----------------------------------------------------------------
// handshake properties
// ----------------------------------------------------------------
module atri_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  awaddr,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire both_w = awvalid && awready && wvalid && wready;
  // read answers exactly one edge after the address is taken
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after address");
  // data must not move while the master stalls
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved before taken");
  read_done_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not released");
  // registers are bytes, upper bits read zero
  read_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  write_answer_a: assert property (both_w |=> !bvalid ##1 bvalid)
    else $error("write response not two edges after request");
  write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response moved before taken");
  write_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not released");
  // an address past the map must be refused
  unmapped_resp_a: assert property (both_w && awaddr >= 8'h20 |-> ##2 bresp == 2'b11)
    else $error("unmapped write not refused");
endmodule
bind atri_top atri_monitor u_atri_monitor (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready));

// ---- tb/atri_top_bench.sv ----
// self-checking bench for the timer register interface
// assumes: atri_top on one 100 MHz clock; crystal pin made here
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module atri_top_bench;
  logic        aclk = 0, aresetn = 0, osc = 0, osc_on = 0, cack = 0, oack = 0;
  logic [7:0]  awaddr = 0, araddr = 0, cmp, v;
  logic [1:0]  gr;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, got, seed_v;
  logic [3:0]  wstrb = 4'h1;
  wire         awready, wready, bvalid, arready, rvalid, cirq, oirq, wave;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          bad_count = 0, n_checks = 0, oc = 0, k;

  atri_top u_atri_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_oscillator_input(osc), .compare_vector_ack(cack), .overflow_vector_ack(oack),
    .compare_irq_req(cirq), .overflow_irq_req(oirq), .waveform_output_pin(wave));

  always #5 aclk = ~aclk;
  // crystal stand-in: ten cycles a period, still while not wanted
  always @(posedge aclk) begin
    oc <= (oc == 4) ? 0 : oc + 1;
    if (osc_on && oc == 4) osc <= ~osc;
  end

  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // one write; a spare edge after keeps readies and drives apart
  task wr(input [7:0] a, input [7:0] d);
    int i;
    begin
      awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 50; i++) begin
        @(posedge aclk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
        if (bvalid) begin gr = bresp; break; end
      end
      bready <= 0;
      if (i == 50) begin bad_count++; end_of_test; end
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a);
    int i;
    begin
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 50; i++) begin
        @(posedge aclk);
        if (arready) arvalid <= 0;
        if (rvalid) begin got = rdata; gr = rresp; break; end
      end
      rready <= 0;
      if (i == 50) begin bad_count++; end_of_test; end
      @(posedge aclk);
    end
  endtask
  task chk_rd(input [7:0] a, input [7:0] e);
    begin rd(a); `CHK(got, {24'h00_0000, e}) end
  endtask

  initial begin
    seed_v = $urandom(6);
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk_rd(8'h0C, 8'h00);
    chk_rd(8'h14, 8'h00);
    chk_rd(8'h18, 8'h00);
    wr(8'h20, 8'hFF);
    `CHK(gr, 2'b11)
    chk_rd(8'h20, 8'h00);
    `CHK(gr, 2'b11)
    cmp = 8'($urandom()) | 8'h10;
    wr(8'h04, cmp);
    `CHK(gr, 2'b00)
    chk_rd(8'h04, cmp);
    `CHK(gr, 2'b00)
    // stopped timer keeps the loaded value
    wr(8'h00, cmp - 8'h05);
    chk_rd(8'h00, cmp - 8'h05);
    // normal mode, undivided, output set on match
    wr(8'h08, 8'h31);
    chk_rd(8'h08, 8'h31);
    repeat (300) @(posedge aclk);
    wr(8'h08, 8'h00);
    `CHK(wave, 1'b1)
    chk_rd(8'h14, 8'hC0);
    wr(8'h14, 8'h00);
    chk_rd(8'h14, 8'hC0);
    wr(8'h14, 8'h80);
    chk_rd(8'h14, 8'h40);
    // request needs mask, global enable and flag together
    wr(8'h10, 8'h40);
    `CHK(oirq, 1'b0)
    wr(8'h1C, 8'h80);
    `CHK(oirq, 1'b1)
    `CHK(cirq, 1'b0)
    @(posedge aclk) oack <= 1;
    @(posedge aclk) oack <= 0;
    repeat (2) @(posedge aclk);
    `CHK(oirq, 1'b0)
    // divide by 8: captures 80 edges apart see exactly ten ticks
    wr(8'h08, 8'h02);
    rd(8'h00);
    v = got[7:0];
    repeat (77) @(posedge aclk);
    rd(8'h00);
    v = got[7:0] - v;
    `CHK(v, 8'(80 / 8))
    // counter loaded equal to compare while stopped: first tick must not match
    wr(8'h08, 8'h00);
    wr(8'h14, 8'hC0);
    wr(8'h00, cmp);
    wr(8'h08, 8'h01);
    rd(8'h14);
    `CHK(got[7], 1'b0)
    // phase-correct: no overflow on the turn at the top, one at the bottom
    wr(8'h08, 8'h00);
    wr(8'h00, 8'hFD);
    wr(8'h14, 8'hC0);
    wr(8'h08, 8'h09);
    repeat (20) @(posedge aclk);
    rd(8'h14);
    `CHK(got[6], 1'b0)
    repeat (520) @(posedge aclk);
    rd(8'h14);
    `CHK(got[6], 1'b1)
    // clear on compare: the counter never passes the compare value
    wr(8'h08, 8'h41);
    repeat (300) @(posedge aclk);
    rd(8'h00);
    `CHK(got[7:0] <= cmp, 1'b1)
    wr(8'h18, 8'h02);
    chk_rd(8'h18, 8'h00);
    // crystal still: every busy flag must stay up
    // after the source change each register is rewritten, once, while idle
    wr(8'h0C, 8'h08);
    wr(8'h00, 8'h33);
    wr(8'h04, cmp);
    wr(8'h08, 8'h00);
    wr(8'h18, 8'h02);
    chk_rd(8'h0C, 8'h0F);
    chk_rd(8'h18, 8'h02);
    osc_on <= 1;
    for (k = 0; k < 40; k++) begin
      rd(8'h0C);
      if (got[2:0] == 3'b000) break;
    end
    `CHK(got, 32'h0000_0008)
    chk_rd(8'h18, 8'h00);
    chk_rd(8'h00, 8'h33);
    end_of_test;
  end
endmodule

// ---- verilog/atri_prescaler.v ----
// timer prescaler: passes the timer source tick undivided or divides it by 8 to 1024
// assumes: src_tick is one cycle per timer clock edge, same clock
`timescale 1ns/1ns

module atri_prescaler (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       src_tick,
  input  wire       clr,
  input  wire [2:0] sel,
  output reg        tick
);

  reg [9:0] div_r;

  // free divider, cleared by the prescaler reset request
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 10'h000;
    end else if (clr) begin
      div_r <= 10'h000;
    end else if (src_tick) begin
      div_r <= div_r + 10'h001;
    end
  end

  // tap selection; select 0 stops the timer
  always @* begin
    case (sel)
      3'd0:    tick = 1'b0;
      3'd1:    tick = 1'b1;
      3'd2:    tick = &div_r[2:0];
      3'd3:    tick = &div_r[4:0];
      3'd4:    tick = &div_r[5:0];
      3'd5:    tick = &div_r[6:0];
      3'd6:    tick = &div_r[7:0];
      default: tick = &div_r[9:0];
    endcase
    tick = tick & src_tick & ~clr;
  end

endmodule

// ---- verilog/atri_sync2.v ----
// two-flop synchroniser for one level arriving from outside the clock
// assumes: aclk is the only clock; the first flop feeds only the second
`timescale 1ns/1ns

module atri_sync2 (
  input  wire aclk,
  input  wire aresetn,
  input  wire d,
  output wire q
);

  reg meta_r;
  reg sync_r;

  // first stage may go metastable, so nothing but sync_r reads it
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// ---- verilog/atri_top.v ----
// asynchronous-capable 8-bit timer with its register interface
// assumes: AXI4-Lite master on aclk; crystal pin sampled as a level;
// vector acknowledge pulses come from logic on aclk
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "atri_defines.vh"

module atri_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        timer_oscillator_input,
  input  wire        compare_vector_ack,
  input  wire        overflow_vector_ack,
  output reg         compare_irq_req,
  output reg         overflow_irq_req,
  output reg         waveform_output_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0] aw_addr_r;
  reg  [7:0] w_data_r;
  reg        w_lane0_r;
  reg        aw_full_r;
  reg        w_full_r;
  reg  [7:0] counter_value_r;
  reg  [7:0] cnt_hold_r;
  reg  [7:0] cmp_hold_r;
  reg  [7:0] compare_value_r;
  reg  [7:0] ctl_hold_r;
  reg  [7:0] timer_control_r;
  reg        cnt_pend_r;
  reg        cmp_pend_r;
  reg        ctl_pend_r;
  reg        psr_pend_r;
  reg        async_clock_select_r;
  reg  [2:0] busy_r;
  reg  [2:0] done1_r;
  reg  [2:0] done2_r;
  reg  [1:0] int_mask_r;
  reg        gie_r;
  reg        compare_flag_r;
  reg        overflow_flag_r;
  reg  [2:0] cmp_dly_r;
  reg  [2:0] ovf_dly_r;
  reg        block_r;
  reg        dir_up_r;
  reg        osc_prev_r;

  wire       osc_s;
  wire       t_tick;
  wire       wr_do;
  wire       wr_en;
  wire       osc_rise;
  wire       clk_edge;
  wire       cnt_ld;
  wire       cmp_ld;
  wire       ctl_ld;
  wire [2:0] ld_vec;
  wire [1:0] wgm;
  wire [1:0] com;

  reg  [7:0] cnt_nxt;
  reg        dir_nxt;
  reg        wave_nxt;
  reg        cmp_evt;
  reg        ovf_evt;
  reg  [7:0] rd_val;
  reg        rd_hit;
  reg        wr_hit;

  // ----------------------------------------------------------------
  // crystal pin and timer clock source
  // ----------------------------------------------------------------
  atri_sync2 u_osc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (timer_oscillator_input),
    .q       (osc_s)
  );

  // edge memory reads only the synchronised copy
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_s;
    end
  end

  assign osc_rise = osc_s & ~osc_prev_r;
  assign clk_edge = async_clock_select_r ? osc_rise : 1'b1;

  atri_prescaler u_presc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_tick (clk_edge),
    .clr      (psr_pend_r & clk_edge),
    .sel      (timer_control_r[2:0]),
    .tick     (t_tick)
  );

  // ----------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------
  assign wr_do = aw_full_r & w_full_r & ~bvalid;
  assign wr_en = wr_do & w_lane0_r & wr_hit;

  // address and data are taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `ATRI_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        aw_full_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r  <= wdata[7:0];
        w_lane0_r <= wstrb[0];
        w_full_r  <= 1'b1;
        wready    <= 1'b0;
      end
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? `ATRI_RESP_OKAY : `ATRI_RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid    <= 1'b0;
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  // write address decode
  always @* begin
    if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_COUNTER) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_COMPARE) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_CONTROL) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_ASYNC) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_MASK) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_FLAGS) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_SFIO) begin
      wr_hit = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_GIE) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  // live counter, holding copies
  always @* begin
    rd_hit = 1'b1;
    if ({araddr[7:2], 2'b00} == `ATRI_OFF_COUNTER) begin
      rd_val = counter_value_r;
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_COMPARE) begin
      rd_val = cmp_hold_r;
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_CONTROL) begin
      rd_val = {1'b0, ctl_hold_r[6:0]}; // force strobe reads zero
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_ASYNC) begin
      rd_val = {4'h0, async_clock_select_r, busy_r};
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_MASK) begin
      rd_val = {int_mask_r, 6'h00};
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_FLAGS) begin
      rd_val = {compare_flag_r, overflow_flag_r, 6'h00};
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_SFIO) begin
      rd_val = {6'h00, psr_pend_r & async_clock_select_r, 1'b0};
    end else if ({araddr[7:2], 2'b00} == `ATRI_OFF_GIE) begin
      rd_val = {gie_r, 7'h00};
    end else begin
      rd_val = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // one read at a time; data captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `ATRI_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_val};
      rresp   <= rd_hit ? `ATRI_RESP_OKAY : `ATRI_RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // holding registers and transfer into the timer
  // ----------------------------------------------------------------
  // loads happen on the next timer clock edge; in sync mode that is
  // the very next cycle, so the holding copy is never stale for long
  assign cnt_ld = cnt_pend_r & clk_edge;
  assign cmp_ld = cmp_pend_r & clk_edge;
  assign ctl_ld = ctl_pend_r & clk_edge;
  assign ld_vec = {cnt_ld, cmp_ld, ctl_ld} & {3{async_clock_select_r}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_hold_r           <= `ATRI_RST_BYTE;
      cmp_hold_r           <= `ATRI_RST_BYTE;
      ctl_hold_r           <= `ATRI_RST_BYTE;
      compare_value_r      <= `ATRI_RST_BYTE;
      timer_control_r      <= `ATRI_RST_BYTE;
      cnt_pend_r           <= 1'b0;
      cmp_pend_r           <= 1'b0;
      ctl_pend_r           <= 1'b0;
      psr_pend_r           <= 1'b0;
      async_clock_select_r <= 1'b0;
      int_mask_r           <= 2'b00;
      gie_r                <= 1'b0;
    end else begin
      // a fresh write wins over the load clearing its pending mark
      if (cnt_ld) cnt_pend_r <= 1'b0;
      if (cmp_ld) begin
        cmp_pend_r      <= 1'b0;
        compare_value_r <= cmp_hold_r;
      end
      if (ctl_ld) begin
        ctl_pend_r      <= 1'b0;
        timer_control_r <= {1'b0, ctl_hold_r[6:0]};
      end
      if (psr_pend_r && clk_edge) psr_pend_r <= 1'b0;
      if (wr_en) begin
        if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_COUNTER) begin
          cnt_hold_r <= w_data_r;
          cnt_pend_r <= 1'b1;
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_COMPARE) begin
          cmp_hold_r <= w_data_r;
          cmp_pend_r <= 1'b1;
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_CONTROL) begin
          ctl_hold_r <= w_data_r;
          ctl_pend_r <= 1'b1;
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_ASYNC) begin
          async_clock_select_r <= w_data_r[`ATRI_AS_SEL_BIT];
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_MASK) begin
          int_mask_r <= w_data_r[7:6];
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_SFIO) begin
          if (w_data_r[`ATRI_PSR_BIT]) psr_pend_r <= 1'b1;
        end else if ({aw_addr_r[7:2], 2'b00} == `ATRI_OFF_GIE) begin
          gie_r <= w_data_r[`ATRI_GIE_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // update-busy flags
  // ----------------------------------------------------------------
  // completion seen back
  always @(posedge aclk) begin
    if (!aresetn) begin
      done1_r <= 3'b000;
      done2_r <= 3'b000;
      busy_r  <= 3'b000;
    end else begin
      done1_r <= ld_vec;
      done2_r <= done1_r;
      busy_r  <= (busy_r & ~done2_r)
               | ({cnt_pend_r, cmp_pend_r, ctl_pend_r} & ~ld_vec
                  & {3{async_clock_select_r}});
    end
  end

  // ----------------------------------------------------------------
  // counter engine
  // ----------------------------------------------------------------
  assign wgm = {timer_control_r[`ATRI_WGM1_BIT], timer_control_r[`ATRI_WGM0_BIT]};
  assign com = timer_control_r[`ATRI_COM_HI:`ATRI_COM_LO];

  always @* begin
    cnt_nxt  = counter_value_r;
    dir_nxt  = dir_up_r;
    wave_nxt = waveform_output_pin;
    cmp_evt  = 1'b0;
    ovf_evt  = 1'b0;
    if (t_tick) begin
      cmp_evt = (counter_value_r == compare_value_r) & ~block_r;
      case (wgm)
        2'b01: begin
          if (dir_up_r) begin
            if (counter_value_r == `ATRI_CNT_MAX) begin
              dir_nxt = 1'b0;
              cnt_nxt = counter_value_r - 8'h01;
            end else begin
              cnt_nxt = counter_value_r + 8'h01;
            end
          end else if (counter_value_r == `ATRI_CNT_BOTTOM) begin
            dir_nxt = 1'b1;
            ovf_evt = 1'b1;
            cnt_nxt = counter_value_r + 8'h01;
          end else begin
            cnt_nxt = counter_value_r - 8'h01;
          end
          if (cmp_evt && com[1] && compare_value_r != `ATRI_CNT_MAX) begin
            wave_nxt = com[0] ^ ~dir_up_r;
          end
        end
        2'b10: begin
          // clear on compare; overflow only if it passes the maximum
          ovf_evt = (counter_value_r == `ATRI_CNT_MAX);
          cnt_nxt = (counter_value_r == compare_value_r) ? `ATRI_CNT_BOTTOM
                                                          : counter_value_r + 8'h01;
          if (cmp_evt) wave_nxt = com[1] ? com[0] : waveform_output_pin ^ com[0];
        end
        2'b11: begin
          ovf_evt = (counter_value_r == `ATRI_CNT_MAX);
          cnt_nxt = counter_value_r + 8'h01;
          if (com[1]) begin
            if (ovf_evt) begin
              wave_nxt = ~com[0];
            end else if (cmp_evt && compare_value_r != `ATRI_CNT_MAX) begin
              wave_nxt = com[0];
            end
          end
        end
        default: begin
          ovf_evt = (counter_value_r == `ATRI_CNT_MAX);
          cnt_nxt = counter_value_r + 8'h01;
          if (cmp_evt) wave_nxt = com[1] ? com[0] : waveform_output_pin ^ com[0];
        end
      endcase
    end
    // forced compare acts on the pin only, never on the flag
    if (ctl_ld && ctl_hold_r[`ATRI_FOC_BIT] && !wgm[0]) begin
      wave_nxt = com[1] ? com[0] : waveform_output_pin ^ com[0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      counter_value_r     <= `ATRI_RST_BYTE;
      block_r             <= 1'b0;
      dir_up_r            <= 1'b1;
      waveform_output_pin <= 1'b0;
    end else begin
      waveform_output_pin <= wave_nxt;
      if (cnt_ld) begin
        counter_value_r <= cnt_hold_r;
        block_r         <= 1'b1;
      end else begin
        counter_value_r <= cnt_nxt;
        dir_up_r        <= dir_nxt;
        if (t_tick) block_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags and requests
  // ----------------------------------------------------------------
  // async flag delay
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_dly_r <= 3'b000;
      ovf_dly_r <= 3'b000;
    end else begin
      cmp_dly_r <= {cmp_dly_r[1:0], cmp_evt};
      ovf_dly_r <= {ovf_dly_r[1:0], ovf_evt};
    end
  end

  // set wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_flag_r   <= 1'b0;
      overflow_flag_r  <= 1'b0;
      compare_irq_req  <= 1'b0;
      overflow_irq_req <= 1'b0;
    end else begin
      compare_flag_r <= (async_clock_select_r ? cmp_dly_r[2] : cmp_evt)
        | (compare_flag_r & ~compare_vector_ack
           & ~(wr_en && {aw_addr_r[7:2], 2'b00} == `ATRI_OFF_FLAGS
               && w_data_r[`ATRI_CMP_FLG_BIT]));
      overflow_flag_r <= (async_clock_select_r ? ovf_dly_r[2] : ovf_evt)
        | (overflow_flag_r & ~overflow_vector_ack
           & ~(wr_en && {aw_addr_r[7:2], 2'b00} == `ATRI_OFF_FLAGS
               && w_data_r[`ATRI_OVF_FLG_BIT]));
      compare_irq_req  <= int_mask_r[1] & gie_r & compare_flag_r;
      overflow_irq_req <= int_mask_r[0] & gie_r & overflow_flag_r;
    end
  end

endmodule
